// File: rtl/ace5x_pkg.sv
/*
 * Shared constants for the extension-signal master end.
 * Assumes the master and the interconnect share one clock and one reset.
 */
package ace5x_pkg;
	// ==========================================================
	// Widths
	localparam int BYTE_W       = 8;  // Bits per data byte
	localparam int RESP_W       = 2;  // Response code width
	localparam int DATA_W_DEF   = 64; // Default data width
	localparam int ADDR_W_DEF   = 32; // Default address width
	localparam int LOOP_W_DEF   = 4;  // Default loopback width
	localparam int TAG_W_DEF    = 8;  // Default user tag width
	localparam int SID_W_DEF    = 8;  // Default stream id width
	localparam int SSID_W_DEF   = 8;  // Default substream id width
	localparam int NSAID_W_DEF  = 4;  // Default access id width
	localparam int VMID_W_DEF   = 4;  // Default VMID extension width
	localparam int POISON_G_DEF = 64; // Data bits per poison bit
	// ==========================================================
	// Values after reset
	localparam logic RST_VALID = 1'b0; // Channels idle after reset
	localparam logic RST_BUSY  = 1'b0; // Loop table empty after reset
endpackage : ace5x_pkg

// File: rtl/ace5_ext_master.sv
/*
 * Master end of the optional extension signals on the write data, write
 * response, read address and read data channels, plus the write address
 * loopback that the response channels echo.
 * Assumes: the interconnect runs on core_clk, answers every request, and
 * keeps its side of the loopback echo. Responses are never stalled.
 */
`timescale 1ns/1ns
// Operation
// - Read data loop echoes read address loop
// - Substream id meaningful only when valid
// - Check codes travel with write/read data
// - Poison marks travel with write/read data
// - Trace tags on data, read address, responses
// - Master supplies read VMID extension
// - Master marks read stream Secure/Non-secure
// - Master supplies read main stream id
// - Master flags already-translated reads
// - Master attaches non-secure access id
// - Master drives loop value with write address
module ace5_ext_master #(
	parameter bit LOOP_EN   = 1'b1,                   // Loopback property
	parameter bit CHK_EN    = 1'b1,                   // Check-type property
	parameter bit POISON_EN = 1'b1,                   // Poison property
	parameter bit TRACE_EN  = 1'b1,                   // Trace property
	parameter bit DVM_EN    = 1'b1,                   // VMID extension property
	parameter bit UT_EN     = 1'b1,                   // Untranslated property
	parameter bit NSAID_EN  = 1'b1,                   // Access id property
	parameter int DATA_W    = ace5x_pkg::DATA_W_DEF,  // Data width
	parameter int ADDR_W    = ace5x_pkg::ADDR_W_DEF,  // Address width
	parameter int LOOP_W    = ace5x_pkg::LOOP_W_DEF,  // Loop index width
	parameter int TAG_W     = ace5x_pkg::TAG_W_DEF,   // User tag width
	parameter int SID_W     = ace5x_pkg::SID_W_DEF,   // Stream id width
	parameter int SSID_W    = ace5x_pkg::SSID_W_DEF,  // Substream id width
	parameter int NSAID_W   = ace5x_pkg::NSAID_W_DEF, // Access id width
	parameter int VMID_W    = ace5x_pkg::VMID_W_DEF,  // VMID ext width
	parameter int POISON_W  = (DATA_W + ace5x_pkg::POISON_G_DEF - 1) / ace5x_pkg::POISON_G_DEF
) (
	input  wire logic                           core_clk,
	input  wire logic                           rst_n,
	// User side: write address
	input  wire logic                           u_aw_valid,
	output logic                                u_aw_ready,
	input  wire logic [ADDR_W-1:0]              u_aw_addr,
	input  wire logic [TAG_W-1:0]               u_aw_tag,
	// User side: write data
	input  wire logic                           u_w_valid,
	output logic                                u_w_ready,
	input  wire logic [DATA_W-1:0]              u_w_data,
	input  wire logic                           u_w_last,
	input  wire logic [POISON_W-1:0]            u_w_poison,
	input  wire logic                           u_w_trace,
	// User side: write response
	output logic                                u_b_valid,
	output logic [ace5x_pkg::RESP_W-1:0]        u_b_resp,
	output logic [TAG_W-1:0]                    u_b_tag,
	output logic                                u_b_trace,
	output logic                                u_b_loop_err,
	// User side: read address
	input  wire logic                           u_ar_valid,
	output logic                                u_ar_ready,
	input  wire logic [ADDR_W-1:0]              u_ar_addr,
	input  wire logic [TAG_W-1:0]               u_ar_tag,
	input  wire logic                           u_ar_trace,
	input  wire logic [VMID_W-1:0]              u_ar_vmidext,
	input  wire logic                           u_ar_secure,
	input  wire logic [SID_W-1:0]               u_ar_sid,
	input  wire logic                           u_ar_ssid_valid,
	input  wire logic [SSID_W-1:0]              u_ar_ssid,
	input  wire logic                           u_ar_translated,
	input  wire logic [NSAID_W-1:0]             u_ar_nsaid,
	// User side: read data
	output logic                                u_r_valid,
	output logic [DATA_W-1:0]                   u_r_data,
	output logic                                u_r_last,
	output logic [TAG_W-1:0]                    u_r_tag,
	output logic [POISON_W-1:0]                 u_r_poison,
	output logic                                u_r_trace,
	output logic                                u_r_chk_err,
	output logic                                u_r_loop_err,
	// Link: write address
	output logic                                awvalid,
	input  wire logic                           awready,
	output logic [ADDR_W-1:0]                   awaddr,
	output logic [LOOP_W-1:0]                   awloop,
	// Link: write data
	output logic                                wvalid,
	input  wire logic                           wready,
	output logic [DATA_W-1:0]                   wdata,
	output logic                                wlast,
	output logic [DATA_W/ace5x_pkg::BYTE_W-1:0] wdatachk,
	output logic [POISON_W-1:0]                 wpoison,
	output logic                                wtrace,
	// Link: write response
	input  wire logic                           bvalid,
	output logic                                bready,
	input  wire logic [ace5x_pkg::RESP_W-1:0]   bresp,
	input  wire logic                           btrace,
	input  wire logic [LOOP_W-1:0]              bloop,
	// Link: read address
	output logic                                arvalid,
	input  wire logic                           arready,
	output logic [ADDR_W-1:0]                   araddr,
	output logic [VMID_W-1:0]                   arvmidext,
	output logic                                artrace,
	output logic [LOOP_W-1:0]                   arloop,
	output logic                                ar_stream_secure,
	output logic [SID_W-1:0]                    ar_stream_id,
	output logic                                ar_substream_valid,
	output logic [SSID_W-1:0]                   ar_substream_id,
	output logic                                ar_translated,
	output logic [NSAID_W-1:0]                  ar_nsaid,
	// Link: read data
	input  wire logic                           rvalid,
	output logic                                rready,
	input  wire logic [DATA_W-1:0]              rdata,
	input  wire logic                           rlast,
	input  wire logic [DATA_W/ace5x_pkg::BYTE_W-1:0] rdatachk,
	input  wire logic [POISON_W-1:0]            rpoison,
	input  wire logic                           rtrace,
	input  wire logic [LOOP_W-1:0]              rloop
);
	import ace5x_pkg::*;

	localparam int DEPTH = 1 << LOOP_W; // Entries in each loop table
	localparam int NBYTE = DATA_W / BYTE_W; // Check bits per beat

	// ==========================================================
	// Helpers
	// Odd parity per byte; used to generate and to check codes
	function automatic logic [NBYTE-1:0] byte_parity(input logic [DATA_W-1:0] d);
		logic [NBYTE-1:0] p;
		p = '0;
		for (int i = 0; i < NBYTE; i++) begin
			p[i] = ~^d[i*BYTE_W +: BYTE_W];
		end
		return p;
	endfunction

	// Lowest free table entry; zero when the table is full
	function automatic logic [LOOP_W-1:0] first_free(input logic [DEPTH-1:0] busy);
		logic [LOOP_W-1:0] idx;
		idx = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (!busy[i]) begin
				idx = LOOP_W'(i);
			end
		end
		return idx;
	endfunction

	// ==========================================================
	// Loop tables
	logic [DEPTH-1:0] w_busy, next_w_busy;   // Write entries in flight
	logic [DEPTH-1:0] r_busy, next_r_busy;   // Read entries in flight
	logic [TAG_W-1:0] w_tab [DEPTH];         // Write user tags by loop index
	logic [TAG_W-1:0] r_tab [DEPTH];         // Read user tags by loop index
	logic [TAG_W-1:0] next_w_tab [DEPTH];
	logic [TAG_W-1:0] next_r_tab [DEPTH];
	logic [LOOP_W-1:0] w_free, r_free;       // Next index to hand out
	logic              w_room, r_room;       // Table has a spare entry
	logic              aw_take, w_take, ar_take; // User handshakes
	logic              b_hit, r_hit;         // Echoed index was in flight

	assign w_free  = first_free(w_busy);
	assign r_free  = first_free(r_busy);
	assign w_room  = !LOOP_EN || !(&w_busy);
	assign r_room  = !LOOP_EN || !(&r_busy);
	assign b_hit   = w_busy[bloop];
	assign r_hit   = r_busy[rloop];

	// Responses are always taken; user outputs are plain pulses
	assign bready = 1'b1;
	assign rready = 1'b1;

	// Issue stages accept when empty or draining; a full table stalls
	assign u_aw_ready = (!awvalid || awready) && w_room;
	assign u_w_ready  = !wvalid || wready;
	assign u_ar_ready = (!arvalid || arready) && r_room;
	assign aw_take    = u_aw_valid && u_aw_ready;
	assign w_take     = u_w_valid && u_w_ready;
	assign ar_take    = u_ar_valid && u_ar_ready;

	// ==========================================================
	// Issue group: next values
	logic                next_awvalid, next_wvalid, next_arvalid;
	logic [ADDR_W-1:0]   next_awaddr, next_araddr;
	logic [LOOP_W-1:0]   next_awloop, next_arloop;
	logic [DATA_W-1:0]   next_wdata;
	logic                next_wlast, next_wtrace, next_artrace;
	logic [NBYTE-1:0]    next_wdatachk;
	logic [POISON_W-1:0] next_wpoison;
	logic [VMID_W-1:0]   next_arvmidext;
	logic                next_ar_stream_secure, next_ar_substream_valid, next_ar_translated;
	logic [SID_W-1:0]    next_ar_stream_id;
	logic [SSID_W-1:0]   next_ar_substream_id;
	logic [NSAID_W-1:0]  next_ar_nsaid;

	// Payload loads only on a user handshake, so it holds while stalled
	always_comb begin
		next_awvalid = awvalid && !awready;
		next_awaddr  = awaddr;
		next_awloop  = awloop;
		if (aw_take) begin
			next_awvalid = 1'b1;
			next_awaddr  = u_aw_addr;
			next_awloop  = LOOP_EN ? w_free : '0;
		end
		next_wvalid   = wvalid && !wready;
		next_wdata    = wdata;
		next_wlast    = wlast;
		next_wdatachk = wdatachk;
		next_wpoison  = wpoison;
		next_wtrace   = wtrace;
		if (w_take) begin
			next_wvalid   = 1'b1;
			next_wdata    = u_w_data;
			next_wlast    = u_w_last;
			next_wdatachk = CHK_EN ? byte_parity(u_w_data) : '0;
			next_wpoison  = POISON_EN ? u_w_poison : '0;
			next_wtrace   = TRACE_EN && u_w_trace;
		end
		next_arvalid            = arvalid && !arready;
		next_araddr             = araddr;
		next_arloop             = arloop;
		next_artrace            = artrace;
		next_arvmidext          = arvmidext;
		next_ar_stream_secure   = ar_stream_secure;
		next_ar_stream_id       = ar_stream_id;
		next_ar_substream_valid = ar_substream_valid;
		next_ar_substream_id    = ar_substream_id;
		next_ar_translated      = ar_translated;
		next_ar_nsaid           = ar_nsaid;
		if (ar_take) begin
			next_arvalid            = 1'b1;
			next_araddr             = u_ar_addr;
			next_arloop             = LOOP_EN ? r_free : '0;
			next_artrace            = TRACE_EN && u_ar_trace;
			next_arvmidext          = DVM_EN ? u_ar_vmidext : '0;
			next_ar_stream_secure   = UT_EN && u_ar_secure;
			next_ar_stream_id       = UT_EN ? u_ar_sid : '0;
			next_ar_substream_valid = UT_EN && u_ar_ssid_valid;
			// Id forced to zero when unqualified so nothing stale leaks out
			next_ar_substream_id    = (UT_EN && u_ar_ssid_valid) ? u_ar_ssid : '0;
			next_ar_translated      = UT_EN && u_ar_translated;
			next_ar_nsaid           = NSAID_EN ? u_ar_nsaid : '0;
		end
	end

	// Issue group: registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awvalid            <= RST_VALID;
			awaddr             <= '0;
			awloop             <= '0;
			wvalid             <= RST_VALID;
			wdata              <= '0;
			wlast              <= 1'b0;
			wdatachk           <= '0;
			wpoison            <= '0;
			wtrace             <= 1'b0;
			arvalid            <= RST_VALID;
			araddr             <= '0;
			arloop             <= '0;
			artrace            <= 1'b0;
			arvmidext          <= '0;
			ar_stream_secure   <= 1'b0;
			ar_stream_id       <= '0;
			ar_substream_valid <= 1'b0;
			ar_substream_id    <= '0;
			ar_translated      <= 1'b0;
			ar_nsaid           <= '0;
		end else begin
			awvalid            <= next_awvalid;
			awaddr             <= next_awaddr;
			awloop             <= next_awloop;
			wvalid             <= next_wvalid;
			wdata              <= next_wdata;
			wlast              <= next_wlast;
			wdatachk           <= next_wdatachk;
			wpoison            <= next_wpoison;
			wtrace             <= next_wtrace;
			arvalid            <= next_arvalid;
			araddr             <= next_araddr;
			arloop             <= next_arloop;
			artrace            <= next_artrace;
			arvmidext          <= next_arvmidext;
			ar_stream_secure   <= next_ar_stream_secure;
			ar_stream_id       <= next_ar_stream_id;
			ar_substream_valid <= next_ar_substream_valid;
			ar_substream_id    <= next_ar_substream_id;
			ar_translated      <= next_ar_translated;
			ar_nsaid           <= next_ar_nsaid;
		end
	end

	// ==========================================================
	// Response group: next values
	logic                next_u_b_valid, next_u_b_trace, next_u_b_loop_err;
	logic [RESP_W-1:0]   next_u_b_resp;
	logic [TAG_W-1:0]    next_u_b_tag, next_u_r_tag;
	logic                next_u_r_valid, next_u_r_last, next_u_r_trace;
	logic                next_u_r_chk_err, next_u_r_loop_err;
	logic [DATA_W-1:0]   next_u_r_data;
	logic [POISON_W-1:0] next_u_r_poison;

	// Release is applied before allocation, so a same-cycle set wins
	always_comb begin
		next_w_busy = w_busy;
		next_r_busy = r_busy;
		next_w_tab  = w_tab;
		next_r_tab  = r_tab;
		if (LOOP_EN && bvalid) begin
			next_w_busy[bloop] = 1'b0;
		end
		if (LOOP_EN && rvalid && rlast) begin
			next_r_busy[rloop] = 1'b0;
		end
		if (LOOP_EN && aw_take) begin
			next_w_busy[w_free] = 1'b1;
			next_w_tab[w_free]  = u_aw_tag;
		end
		if (LOOP_EN && ar_take) begin
			next_r_busy[r_free] = 1'b1;
			next_r_tab[r_free]  = u_ar_tag;
		end
		// An echo of an index not in flight is reported, not trusted
		next_u_b_valid    = bvalid;
		next_u_b_resp     = bresp;
		next_u_b_tag      = LOOP_EN ? w_tab[bloop] : '0;
		next_u_b_trace    = TRACE_EN && btrace;
		next_u_b_loop_err = LOOP_EN && bvalid && !b_hit;
		next_u_r_valid    = rvalid;
		next_u_r_data     = rdata;
		next_u_r_last     = rlast;
		next_u_r_tag      = LOOP_EN ? r_tab[rloop] : '0;
		next_u_r_poison   = POISON_EN ? rpoison : '0;
		next_u_r_trace    = TRACE_EN && rtrace;
		next_u_r_chk_err  = CHK_EN && rvalid && (rdatachk != byte_parity(rdata));
		next_u_r_loop_err = LOOP_EN && rvalid && !r_hit;
	end

	// Response group: registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_busy       <= {DEPTH{RST_BUSY}};
			r_busy       <= {DEPTH{RST_BUSY}};
			w_tab        <= '{default: '0};
			r_tab        <= '{default: '0};
			u_b_valid    <= RST_VALID;
			u_b_resp     <= '0;
			u_b_tag      <= '0;
			u_b_trace    <= 1'b0;
			u_b_loop_err <= 1'b0;
			u_r_valid    <= RST_VALID;
			u_r_data     <= '0;
			u_r_last     <= 1'b0;
			u_r_tag      <= '0;
			u_r_poison   <= '0;
			u_r_trace    <= 1'b0;
			u_r_chk_err  <= 1'b0;
			u_r_loop_err <= 1'b0;
		end else begin
			w_busy       <= next_w_busy;
			r_busy       <= next_r_busy;
			w_tab        <= next_w_tab;
			r_tab        <= next_r_tab;
			u_b_valid    <= next_u_b_valid;
			u_b_resp     <= next_u_b_resp;
			u_b_tag      <= next_u_b_tag;
			u_b_trace    <= next_u_b_trace;
			u_b_loop_err <= next_u_b_loop_err;
			u_r_valid    <= next_u_r_valid;
			u_r_data     <= next_u_r_data;
			u_r_last     <= next_u_r_last;
			u_r_tag      <= next_u_r_tag;
			u_r_poison   <= next_u_r_poison;
			u_r_trace    <= next_u_r_trace;
			u_r_chk_err  <= next_u_r_chk_err;
			u_r_loop_err <= next_u_r_loop_err;
		end
	end

	// ==========================================================
	// Assertions
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic b_lost, r_lost; // Echo of an index not in flight
	assign b_lost = LOOP_EN && bvalid && !b_hit;
	assign r_lost = LOOP_EN && rvalid && !r_hit;

	sequence aw_stall_s;
		awvalid && !awready;
	endsequence
	sequence ar_issue_s;
		ar_take ##1 arvalid;
	endsequence

	aw_loop_hold_a: assert property (aw_stall_s |=> awvalid && $stable(awloop))
		else $error("awloop changed while write address stalled");
	b_echo_err_a: assert property (bvalid |=> u_b_valid && (u_b_loop_err == $past(b_lost)))
		else $error("write echo error flag wrong");
	r_echo_err_a: assert property (rvalid |=> u_r_valid && (u_r_loop_err == $past(r_lost)))
		else $error("read echo error flag wrong");
	ssid_qual_a: assert property (arvalid && !ar_substream_valid |-> ar_substream_id == '0)
		else $error("substream id driven without qualifier");
	w_check_a: assert property (wvalid |-> wdatachk == (CHK_EN ? byte_parity(wdata) : '0))
		else $error("write check code does not match data");
	w_poison_a: assert property (w_take |=> wpoison == (POISON_EN ? $past(u_w_poison) : '0))
		else $error("write poison not carried");
	ar_trace_a: assert property (ar_issue_s |-> artrace == (TRACE_EN && $past(u_ar_trace)))
		else $error("read address trace not carried");
	ar_vmid_a: assert property (ar_take |=> arvalid && arvmidext == (DVM_EN ? $past(u_ar_vmidext) : '0))
		else $error("vmid extension not carried");
	ar_secure_a: assert property (ar_issue_s |-> ar_stream_secure == (UT_EN && $past(u_ar_secure)))
		else $error("stream security not carried");
	ar_sid_a: assert property (arvalid && !arready |=> $stable(ar_stream_id) && $stable(ar_translated))
		else $error("stream id changed while stalled");
	ar_atst_a: assert property (ar_take |=> ar_translated == (UT_EN && $past(u_ar_translated)))
		else $error("translated flag not carried");
	ar_nsaid_a: assert property (ar_take |=> ar_nsaid == (NSAID_EN ? $past(u_ar_nsaid) : '0))
		else $error("access id not carried");
	off_zero_a: assert property (!LOOP_EN |-> awloop == '0 && arloop == '0 && !u_b_loop_err)
		else $error("loopback active while disabled");

endmodule // ace5_ext_master

// File: verification/ic_model.sv
/* Behavioural interconnect facing the master end: accepts writes and reads, echoes loop values.
   Assumes one core_clk, bready/rready always high, single-beat reads. */
`timescale 1ns/1ns
module ic_model (
	input  wire logic        core_clk, rst_n, slow, bad_chk,
	input  wire logic        awvalid, wvalid, wlast, wtrace, bready, arvalid, artrace, ar_substream_valid, rready,
	input  wire logic [3:0]  awloop, arloop,
	input  wire logic [7:0]  ar_substream_id,
	input  wire logic [31:0] araddr,
	output logic             awready, wready, arready, bvalid, btrace, rvalid, rlast, rpoison, rtrace,
	output logic [1:0]       bresp,
	output logic [3:0]       bloop, rloop,
	output logic [7:0]       rdatachk,
	output logic [63:0]      rdata
);
	// ==========================================
	// Acceptance and responses
	logic       rdy; // Toggles when slow, to stall requests
	logic [3:0] aq[$]; // Write loop values waiting for data
	logic       tq[$]; // Write trace marks of finished bursts
	logic [63:0] rd_word; // Read data pattern for the current address
	assign rd_word = {~araddr, araddr};
	assign awready = rdy;
	assign wready  = rdy;
	assign arready = rdy;
	// One process keeps all channel state; idle bloop and rdata invert so stale values never look valid
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy <= 1'h1;
			bvalid <= 1'h0;
			rvalid <= 1'h0;
			bresp <= 2'h0;
			rlast <= 1'h1;
		end else begin
			rdy <= slow ? ~rdy : 1'h1;
			bvalid <= 1'h0;
			bloop <= ~bloop;
			rvalid <= 1'h0;
			rdata <= ~rdata;
			if (aq.size() > 0 && tq.size() > 0) begin
				bvalid <= 1'h1;
				// bad_chk also corrupts the echoes, so the master must flag them
				bloop <= aq.pop_front() ^ {3'h0, bad_chk};
				btrace <= tq.pop_front();
			end
			if (awvalid && awready) aq.push_back(awloop);
			if (wvalid && wready && wlast) tq.push_back(wtrace);
			if (arvalid && arready) begin
				rvalid <= 1'h1;
				rloop <= arloop ^ {3'h0, bad_chk};
				rtrace <= artrace;
				rdata <= rd_word;
				rpoison <= ar_substream_valid & ar_substream_id[0];
				for (int i = 0; i < 8; i++) rdatachk[i] <= (~^rd_word[8*i+:8]) ^ (i == 0 && bad_chk);
			end
		end
	end
endmodule // ic_model

// File: verification/tb.sv
/* Self-checking bench for the master end of the extension signals.
   Assumes default widths: data 64, address 32, loop 4, tag 8, one poison bit. */
`timescale 1ns/1ns
module tb;
	// ==========================================
	// Signals, named as the ports so both instances connect by name
	logic        core_clk, rst_n, slow, bad_chk, u_aw_valid, u_aw_ready, u_w_valid, u_w_ready, u_w_last, u_w_poison;
	logic        u_w_trace, u_b_valid, u_b_trace, u_b_loop_err, u_ar_valid, u_ar_ready, u_ar_trace, u_ar_secure;
	logic        u_ar_ssid_valid, u_ar_translated, u_r_valid, u_r_last, u_r_poison, u_r_trace, u_r_chk_err, u_r_loop_err;
	logic        awvalid, awready, wvalid, wready, wlast, wpoison, wtrace, bvalid, bready, btrace, arvalid, arready;
	logic        artrace, ar_stream_secure, ar_substream_valid, ar_translated, rvalid, rready, rlast, rpoison, rtrace;
	logic [1:0]  u_b_resp, bresp;
	logic [3:0]  u_ar_vmidext, u_ar_nsaid, awloop, bloop, arloop, rloop, arvmidext, ar_nsaid;
	logic [7:0]  u_aw_tag, u_b_tag, u_ar_tag, u_r_tag, u_ar_sid, u_ar_ssid, ar_stream_id, ar_substream_id;
	logic [7:0]  wdatachk, rdatachk;
	logic [31:0] u_aw_addr, u_ar_addr, awaddr, araddr;
	logic [63:0] u_w_data, u_r_data, wdata, rdata;
	logic [11:0] bq[$]; // Write responses seen
	logic [76:0] rq[$]; // Read beats seen
	logic [9:0]  wcap; // Write data sideband at handshake
	logic [27:0] arcap; // Read address sideband at handshake
	int          err_total, tests_run;
	ace5_ext_master dut (.*);
	ic_model partner (.*);
	// Clock, 40 ns period
	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end
	// Monitors sample at the falling edge, where everything has settled
	always @(negedge core_clk) begin
		if (u_b_valid === 1'h1) bq.push_back({u_b_loop_err, u_b_trace, u_b_resp, u_b_tag});
		if (u_r_valid === 1'h1) rq.push_back({u_r_last, u_r_loop_err, u_r_chk_err, u_r_trace, u_r_poison, u_r_tag, u_r_data});
		if (wvalid === 1'h1 && wready === 1'h1) wcap = {wtrace, wpoison, wdatachk};
		if (arvalid === 1'h1 && arready === 1'h1)
			arcap = {arvmidext, ar_stream_secure, ar_stream_id, ar_substream_valid, ar_substream_id, ar_translated, ar_nsaid, artrace};
	end
	// ==========================================
	// Shared tasks
	function automatic logic [7:0] par(input logic [63:0] d);
		for (int i = 0; i < 8; i++) par[i] = ~^d[8*i+:8];
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Bounded wait: a hang counts against the run and ends it
	task automatic lim(input logic ok);
		chk("wait_done", ok, 1'h1);
		if (!ok) tally_and_finish();
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] t, input logic [63:0] d, input logic tr);
		int n;
		logic pa, pw; // Requests not yet taken
		@(posedge core_clk);
		{u_aw_valid, u_aw_addr, u_aw_tag} <= {1'h1, a, t};
		{u_w_valid, u_w_data, u_w_last, u_w_poison, u_w_trace} <= {1'h1, d, 1'h1, 1'h1, tr};
		pa = 1'h1;
		pw = 1'h1;
		// Ready seen at the falling edge means taken at the next rising edge
		for (n = 0; n < 40 && (pa || pw); n++) begin
			@(negedge core_clk);
			pa = pa && !u_aw_ready;
			pw = pw && !u_w_ready;
			@(posedge core_clk);
			if (!pa) u_aw_valid <= 1'h0;
			if (!pw) u_w_valid <= 1'h0;
		end
		lim(n < 40);
	endtask
	task automatic rd(input logic [31:0] a, input logic [7:0] t, input logic sv, input logic [7:0] ss);
		int n;
		logic pa; // Request not yet taken
		@(posedge core_clk);
		{u_ar_valid, u_ar_addr, u_ar_tag, u_ar_trace, u_ar_ssid_valid, u_ar_ssid} <= {1'h1, a, t, 1'h1, sv, ss};
		pa = 1'h1;
		for (n = 0; n < 40 && pa; n++) begin
			@(negedge core_clk);
			pa = !u_ar_ready;
			@(posedge core_clk);
			if (!pa) u_ar_valid <= 1'h0;
		end
		lim(n < 40);
	endtask
	task automatic wait_q(input logic rd_q, input int want);
		int n;
		for (n = 0; n < 40 && (rd_q ? rq.size() : bq.size()) < want; n++) @(negedge core_clk);
		lim(n < 40);
	endtask
	// ==========================================
	// Scenarios
	task automatic s_write();
		bq.delete();
		wr(32'h100, 8'h11, 64'h0123456789abcdef, 1'h1);
		wait_q(1'h0, 1);
		chk("b_single", bq[0], {1'h0, 1'h1, 2'h0, 8'h11});
		chk("w_side", wcap, {1'h1, 1'h1, par(64'h0123456789abcdef)});
	endtask
	// Stalling partner, two writes in a row, answers in order
	task automatic s_b2b();
		bq.delete();
		slow <= 1'h1;
		wr(32'h200, 8'h21, 64'h00000000000000ff, 1'h0);
		wr(32'h204, 8'h22, 64'h0000000000000001, 1'h1);
		wait_q(1'h0, 2);
		chk("b_first", bq[0], {1'h0, 1'h0, 2'h0, 8'h21});
		chk("b_second", bq[1], {1'h0, 1'h1, 2'h0, 8'h22});
		slow <= 1'h0;
	endtask
	task automatic s_read(input logic sv);
		rq.delete();
		rd(32'h3000, 8'h31, sv, 8'h5b);
		wait_q(1'h1, 1);
		chk("ar_side", arcap, {4'ha, 1'h1, 8'h3c, sv, sv ? 8'h5b : 8'h00, 1'h1, 4'h5, 1'h1});
		chk("r_flags", rq[0][75:64], {1'h0, 1'h0, 1'h1, sv, 8'h31});
		chk("r_data", rq[0][63:0], {~32'h3000, 32'h3000});
		chk("r_last", rq[0][76], 1'h1);
	endtask
	// Corrupted check code and wrong loop echoes must be flagged
	task automatic s_bad();
		rq.delete();
		bq.delete();
		bad_chk <= 1'h1;
		rd(32'h4000, 8'h41, 1'h0, 8'h00);
		wr(32'h500, 8'h51, 64'h0, 1'h0);
		wait_q(1'h1, 1);
		wait_q(1'h0, 1);
		chk("r_chk_err", rq[0][74], 1'h1);
		chk("r_loop_err", rq[0][75], 1'h1);
		chk("b_loop_err", bq[0][11], 1'h1);
		bad_chk <= 1'h0;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{rst_n, slow, bad_chk, u_aw_valid, u_w_valid, u_ar_valid, u_w_last, u_w_poison, u_w_trace} = 9'h0;
		{u_aw_addr, u_aw_tag, u_w_data, u_ar_addr, u_ar_tag, u_ar_trace, u_ar_ssid_valid, u_ar_ssid} = '0;
		{u_ar_vmidext, u_ar_secure, u_ar_sid, u_ar_translated, u_ar_nsaid} = {4'ha, 1'h1, 8'h3c, 1'h1, 4'h5};
		{err_total, tests_run} = 0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'h1;
		s_write();
		s_b2b();
		s_read(1'h0);
		s_read(1'h1);
		s_bad();
		tally_and_finish();
	end
endmodule // tb
